//--- core/fap_ctrl.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
// Contract
// - disable fuse x programmed with re-enable x erased cancels access protection.
// - re-enable fuse x programmed with disable x+1 erased restores protection.
// - first disable fuse programs only after debug and access fuses are programmed.
// - disable fuse x programs only after re-enable fuse x-1 is programmed.
// - re-enable fuse x programs only after disable fuse x is programmed.
// - protected primary flash data readable only by code running from it.
// - at most sixteen permanent unlock and relock cycles exist.
// - writes to protected flash from internal ram leave flash unchanged.
// - reads of protected flash from internal ram return a dummy value.
// - peripheral event transfers to protected flash are blocked.
// - extension flash is never access protected.
// - only primary flash code writes flash registers while protected; all may read.
// - writes to a sector whose protect bit is programmed are inhibited.
// - set-protection writing 1 to sector bits lifts their protection temporarily.
// - temporary access unlock accepted only from code in a flash module.
// - lifted protections return on reset or set-protection writing 0.
// - temporary unlock sets only the volatile copy; fuse reads stay 0.
// - code from another flash bank may update protected flash directly.
// - programmed debug fuse disables debug; erased debug fuse lets debug bypass.
// - set-protection is refused when issued from bank two.
module fap_ctrl
    import fap_pkg::*;
(
    // clock and resets
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PWR_ON_N,
    // register port
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire fap_src_type REG_SRC,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic REG_REFUSED,
    // flash data access
    input wire fap_req_type ACC_REQ,
    input wire logic [DATA_W-1:0] FLASH_RDATA,
    output logic ACC_GRANT,
    output logic ACC_DENY,
    output logic [DATA_W-1:0] ACC_RDATA,
    // protection state
    output logic DEBUG_EN,
    output logic PROT_ACTIVE
);

    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    fap_state_type state_r;
    logic [NUM_WP_REGS-1:0][DATA_W-1:0] fuse_wp_r;
    logic [NUM_WP_REGS-1:0][DATA_W-1:0] vol_wp_r;
    logic [1:0] fuse_ap_r;
    logic vol_acc_r;
    logic [NUM_PAIRS-1:0] fuse_pds_r;
    logic [NUM_PAIRS-1:0] fuse_pen_r;
    logic [NUM_PAIRS-1:0] cancel_vec;
    logic [NUM_PAIRS-1:0] pds_allow;
    logic [NUM_WP_REGS-1:0] wp_sel;
    logic [NUM_WP_REGS*DATA_W-1:0] vol_wp_flat;
    logic prot_eff;
    logic dbg_open;
    logic run;
    logic src_prim;
    logic src_flash;
    logic reg_ok;
    logic sel_acc;
    logic sel_unl;
    logic sel_rel;
    logic sel_fuse;
    logic wr_ok;
    logic pds_bad;
    logic pen_bad;
    logic req_prim;
    logic req_flash;
    logic bypass;
    logic blk_acc;
    logic blk_wp;
    logic deny;

    // ----------------------------------------
    // derived protection state
    // ----------------------------------------
    // each consumed pair is walked strictly in order, so only the newest
    // open pair can cancel; sixteen pairs bound the cycles
    for (genvar x = 0; x < NUM_PAIRS; x++) begin : g_pair
        assign cancel_vec[x] = ~fuse_pds_r[x] & fuse_pen_r[x];
        if (x == 0) begin : g_first
            assign pds_allow[x] = ~fuse_ap_r[DBG_BIT] & ~fuse_ap_r[ACC_BIT];
        end else begin : g_next
            assign pds_allow[x] = ~fuse_pen_r[x-1];
        end
    end

    assign vol_wp_flat = vol_wp_r;
    assign run = (state_r == ST_RUN);
    assign prot_eff = ~vol_acc_r & ~(|cancel_vec);
    assign dbg_open = fuse_ap_r[DBG_BIT];
    assign src_prim = (REG_SRC == SRC_PRIM_B0) || (REG_SRC == SRC_PRIM_B1);
    assign src_flash = src_prim || (REG_SRC == SRC_EXT_B2) || (REG_SRC == SRC_EXT_B3);

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    assign sel_acc = (REG_ADDR == OFF_ACC_FUSE);
    assign sel_unl = (REG_ADDR == OFF_UNLOCK);
    assign sel_rel = (REG_ADDR == OFF_RELOCK);
    assign sel_fuse = sel_acc | sel_unl | sel_rel | (|wp_sel);
    // bank two may not run set-protection; protected registers only from primary
    assign reg_ok = run && (REG_SRC != SRC_EXT_B2) && (!prot_eff || src_prim);
    assign wr_ok = REG_WR && reg_ok;
    // a program request for an erased bit whose predecessor is not yet set
    assign pds_bad = |(~REG_WDATA & ~pds_allow & fuse_pds_r);
    assign pen_bad = |(~REG_WDATA & fuse_pds_r & fuse_pen_r);

    for (genvar i = 0; i < NUM_WP_REGS; i++) begin : g_wp
        assign wp_sel[i] = (REG_ADDR == OFF_WP_BASE + OFF_WP_STEP * 24'(i));

        // fuse cells only ever go from 1 to 0
        always_ff @(posedge SYS_CLK or negedge PWR_ON_N) begin
            if (!PWR_ON_N) begin
                fuse_wp_r[i] <= FUSE_ERASED;
            end else if (wr_ok && wp_sel[i]) begin
                fuse_wp_r[i] <= fuse_wp_r[i] & REG_WDATA;
            end
        end

        // volatile copy: a 1 lifts a sector, a 0 restores it
        always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
                vol_wp_r[i] <= '0;
            end else if (!run) begin
                vol_wp_r[i] <= fuse_wp_r[i];
            end else if (wr_ok && wp_sel[i]) begin
                vol_wp_r[i] <= REG_WDATA;
            end
        end
    end

    // ----------------------------------------
    // access, unlock and relock fuses
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge PWR_ON_N) begin
        if (!PWR_ON_N) begin
            fuse_ap_r <= FUSE_ERASED[DBG_BIT:ACC_BIT];
        end else if (wr_ok && sel_acc) begin
            fuse_ap_r <= fuse_ap_r & REG_WDATA[DBG_BIT:ACC_BIT];
        end
    end

    // only allowed bits program; the rest of the word keeps its cells
    always_ff @(posedge SYS_CLK or negedge PWR_ON_N) begin
        if (!PWR_ON_N) begin
            fuse_pds_r <= FUSE_ERASED;
        end else if (wr_ok && sel_unl) begin
            fuse_pds_r <= fuse_pds_r & ~(~REG_WDATA & pds_allow);
        end
    end

    always_ff @(posedge SYS_CLK or negedge PWR_ON_N) begin
        if (!PWR_ON_N) begin
            fuse_pen_r <= FUSE_ERASED;
        end else if (wr_ok && sel_rel) begin
            fuse_pen_r <= fuse_pen_r & ~(~REG_WDATA & ~fuse_pds_r);
        end
    end

    // ----------------------------------------
    // volatile access bit and load sequence
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_LOAD;
        end else begin
            state_r <= ST_RUN;
        end
    end

    // a lift from ram or external code is ignored, a restore is taken from any source but bank two
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            vol_acc_r <= 1'b0;
        end else if (!run) begin
            vol_acc_r <= fuse_ap_r[ACC_BIT];
        end else if (wr_ok && sel_acc) begin
            if (!REG_WDATA[ACC_BIT]) begin
                vol_acc_r <= 1'b0;
            end else if (src_flash) begin
                vol_acc_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // register read and refusal report
    // ----------------------------------------
    // fuse reads show the cells, never the volatile lift
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= '0;
            for (int k = 0; k < NUM_WP_REGS; k++) begin
                if (wp_sel[k]) begin
                    REG_RDATA <= fuse_wp_r[k];
                end
            end
            if (sel_acc) begin
                REG_RDATA[DBG_BIT:ACC_BIT] <= fuse_ap_r;
            end
            if (sel_unl) begin
                REG_RDATA <= fuse_pds_r;
            end
            if (sel_rel) begin
                REG_RDATA <= fuse_pen_r;
            end
            if (REG_ADDR == OFF_STATUS) begin
                REG_RDATA[ST_LOADED_BIT] <= run;
                REG_RDATA[ST_PROT_BIT] <= prot_eff;
                REG_RDATA[ST_CANCEL_BIT] <= |cancel_vec;
                REG_RDATA[ST_DBG_BIT] <= dbg_open;
            end
        end
    end

    // one-cycle pulse for a set-protection write refused or asking for disallowed fuse bits; an ignored lift gives none
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_REFUSED <= 1'b0;
        end else begin
            REG_REFUSED <= REG_WR && sel_fuse && (!reg_ok || (sel_unl && pds_bad)
                || (sel_rel && pen_bad));
        end
    end

    // ----------------------------------------
    // flash data access check
    // ----------------------------------------
    assign req_prim = (ACC_REQ.src == SRC_PRIM_B0) || (ACC_REQ.src == SRC_PRIM_B1);
    assign req_flash = req_prim || (ACC_REQ.src == SRC_EXT_B2)
        || (ACC_REQ.src == SRC_EXT_B3);
    assign bypass = ACC_REQ.dbg && dbg_open;
    // writes may come from any flash bank, reads only from primary itself
    assign blk_acc = ACC_REQ.primary && prot_eff && !bypass && (ACC_REQ.peripheral_event_transfer
        || (ACC_REQ.write ? !req_flash : !req_prim));
    assign blk_wp = ACC_REQ.write && !vol_wp_flat[ACC_REQ.sector] && !bypass;
    assign deny = !run || blk_acc || blk_wp || (ACC_REQ.dbg && !dbg_open);

    // judged against the request of this very cycle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACC_GRANT <= 1'b0;
            ACC_DENY <= 1'b0;
            ACC_RDATA <= DUMMY_DATA;
        end else begin
            ACC_GRANT <= ACC_REQ.valid && !deny;
            ACC_DENY <= ACC_REQ.valid && deny;
            ACC_RDATA <= (ACC_REQ.valid && !ACC_REQ.write && !deny) ? FLASH_RDATA
                : DUMMY_DATA;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DEBUG_EN <= 1'b0;
            PROT_ACTIVE <= 1'b1;
        end else begin
            DEBUG_EN <= dbg_open;
            PROT_ACTIVE <= prot_eff || !run;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_dummy_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && !ACC_REQ.write && ACC_REQ.primary && !ACC_REQ.dbg
        && ACC_REQ.src == SRC_INTERNAL_RAM && prot_eff
        |=> ACC_DENY && ACC_RDATA == DUMMY_DATA;
    endproperty
    a_dummy_read: assert property (p_dummy_read) else $error("dummy read missing");

    property p_ram_write;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && ACC_REQ.write && ACC_REQ.primary && !ACC_REQ.dbg
        && ACC_REQ.src == SRC_INTERNAL_RAM && prot_eff |=> !ACC_GRANT;
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("ram write granted");

    property p_pec_block;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && ACC_REQ.peripheral_event_transfer && ACC_REQ.primary && !ACC_REQ.dbg && prot_eff
        |=> ACC_DENY && !ACC_GRANT;
    endproperty
    a_pec_block: assert property (p_pec_block) else $error("transfer granted");

    property p_ext_open;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && !ACC_REQ.primary && !ACC_REQ.write && !ACC_REQ.dbg && run
        |=> ACC_GRANT;
    endproperty
    a_ext_open: assert property (p_ext_open) else $error("extension refused");

    property p_sector_wp;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && ACC_REQ.write && !ACC_REQ.dbg
        && !vol_wp_flat[ACC_REQ.sector] |=> ACC_DENY;
    endproperty
    a_sector_wp: assert property (p_sector_wp) else $error("sector write passed");

    property p_first_pds;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !fuse_pds_r[0] |-> !fuse_ap_r[ACC_BIT] && !fuse_ap_r[DBG_BIT];
    endproperty
    a_first_pds: assert property (p_first_pds) else $error("unlock out of order");

    property p_pair_order;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (~fuse_pds_r[NUM_PAIRS-1:1] & fuse_pen_r[NUM_PAIRS-2:0]) == '0;
    endproperty
    a_pair_order: assert property (p_pair_order) else $error("pair skipped");

    property p_pen_order;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (~fuse_pen_r & fuse_pds_r) == '0;
    endproperty
    a_pen_order: assert property (p_pen_order) else $error("relock before unlock");

    property p_load;
        @(posedge SYS_CLK) disable iff (!RST_N)
        $rose(run) |-> $past(ACC_GRANT) == 1'b0 && vol_acc_r == $past(fuse_ap_r[ACC_BIT]);
    endproperty
    a_load: assert property (p_load) else $error("load sequence broken");

    property p_temp_lift;
        @(posedge SYS_CLK) disable iff (!RST_N)
        wr_ok && sel_acc && REG_WDATA[ACC_BIT] && src_flash
        |=> vol_acc_r && fuse_ap_r[ACC_BIT] == $past(fuse_ap_r[ACC_BIT]);
    endproperty
    a_temp_lift: assert property (p_temp_lift) else $error("lift wrong");

    property p_reg_guard;
        @(posedge SYS_CLK) disable iff (!RST_N)
        REG_WR && sel_fuse && run && prot_eff && !src_prim
        |=> $stable(fuse_pds_r) && $stable(fuse_pen_r) && REG_REFUSED;
    endproperty
    a_reg_guard: assert property (p_reg_guard) else $error("register write taken");

    // once loaded, code running from the primary flash always reads its own data
    property p_prim_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && !ACC_REQ.write && !ACC_REQ.peripheral_event_transfer && ACC_REQ.primary && !ACC_REQ.dbg
        && run && (ACC_REQ.src == SRC_PRIM_B0 || ACC_REQ.src == SRC_PRIM_B1) |=> ACC_GRANT;
    endproperty
    a_prim_read: assert property (p_prim_read) else $error("primary read refused");

    // an update from the extension banks to an open sector needs no temporary access lift
    property p_other_bank;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ACC_REQ.valid && ACC_REQ.write && !ACC_REQ.peripheral_event_transfer && ACC_REQ.primary && !ACC_REQ.dbg
        && run && vol_wp_flat[ACC_REQ.sector]
        && (ACC_REQ.src == SRC_EXT_B2 || ACC_REQ.src == SRC_EXT_B3) |=> ACC_GRANT;
    endproperty
    a_other_bank: assert property (p_other_bank) else $error("bank update refused");

    property p_relock_write;
        @(posedge SYS_CLK) disable iff (!RST_N)
        wr_ok && sel_acc && !REG_WDATA[ACC_BIT] |=> !vol_acc_r && !fuse_ap_r[ACC_BIT];
    endproperty
    a_relock_write: assert property (p_relock_write) else $error("restore not taken");

    // bank two can neither program nor lift anything
    property p_bank_two;
        @(posedge SYS_CLK) disable iff (!RST_N)
        REG_WR && run && sel_fuse && REG_SRC == SRC_EXT_B2
        |=> REG_REFUSED && $stable(fuse_ap_r) && $stable(vol_wp_flat);
    endproperty
    a_bank_two: assert property (p_bank_two) else $error("bank two write taken");

endmodule

//--- core/fap_pkg.sv
package fap_pkg;

    // ----------------------------------------
    // register map (16-bit registers at byte offsets)
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [23:0] OFF_WP_BASE = 24'h0edfb0;
    localparam logic [23:0] OFF_WP_STEP = 24'h000002;
    localparam logic [23:0] OFF_ACC_FUSE = 24'h0edfb8;
    localparam logic [23:0] OFF_UNLOCK = 24'h0edfbc;
    localparam logic [23:0] OFF_RELOCK = 24'h0edfbe;
    localparam logic [23:0] OFF_STATUS = 24'h0edfc0;

    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int NUM_WP_REGS = 4;
    localparam int NUM_PAIRS = 16;
    localparam int SECT_W = 6;
    localparam int ACC_BIT = 0;
    localparam int DBG_BIT = 1;
    localparam int ST_LOADED_BIT = 0;
    localparam int ST_PROT_BIT = 1;
    localparam int ST_CANCEL_BIT = 2;
    localparam int ST_DBG_BIT = 3;
    localparam logic [15:0] FUSE_ERASED = 16'hffff;
    localparam logic [15:0] DUMMY_DATA = 16'h0000;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SRC_PRIM_B0,
        SRC_PRIM_B1,
        SRC_EXT_B2,
        SRC_EXT_B3,
        SRC_INTERNAL_RAM,
        SRC_EXTENSION_RAM,
        SRC_EXTMEM
    } fap_src_type;

    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } fap_state_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic peripheral_event_transfer;
        logic dbg;
        logic primary;
        fap_src_type src;
        logic [SECT_W-1:0] sector;
    } fap_req_type;

endpackage

//--- sim/fap_flash_model.sv
`timescale 1ns/10ps
module fap_flash_model
    import fap_pkg::*;
(
    // clock
    input wire logic clk,
    // request and answer at the controller
    input wire fap_req_type req,
    input wire logic grant,
    // stored word of the addressed sector
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem_r [64];
    logic [DATA_W-1:0] last_r;
    fap_req_type held_r;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // each sector starts with a word that names it, so a wrong sector shows
    initial begin
        last_r = 16'h0000;
        held_r = '0;
        for (int i = 0; i < 64; i++) begin
            mem_r[i] = 16'ha500 | 16'(i);
        end
    end

    // a granted write inverts the word; a refused one leaves it alone
    always @(posedge clk) begin
        held_r <= req;
        if (req.valid) begin
            last_r <= mem_r[req.sector];
        end
        if (grant && held_r.valid && held_r.write) begin
            mem_r[held_r.sector] <= ~mem_r[held_r.sector];
        end
    end

    // outside a request the bus shows no stale word, only its inverse
    always_comb begin
        rdata = req.valid ? mem_r[req.sector] : ~last_r;
    end
endmodule

//--- sim/fap_ctrl_tb.sv
`timescale 1ns/10ps
module fap_ctrl_tb import fap_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr_on_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    fap_src_type reg_src = SRC_PRIM_B0;
    fap_req_type acc_req = '0;
    logic [DATA_W-1:0] flash_rdata, reg_rdata, acc_rdata;
    logic reg_refused, acc_grant, acc_deny, debug_en, prot_active;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] u, r;

    fap_ctrl DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .PWR_ON_N(pwr_on_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_SRC(reg_src), .REG_RDATA(reg_rdata), .REG_REFUSED(reg_refused),
        .ACC_REQ(acc_req), .FLASH_RDATA(flash_rdata), .ACC_GRANT(acc_grant),
        .ACC_DENY(acc_deny), .ACC_RDATA(acc_rdata), .DEBUG_EN(debug_en),
        .PROT_ACTIVE(prot_active));
    fap_flash_model far_end (.clk(sys_clk), .req(acc_req), .grant(acc_grant),
        .rdata(flash_rdata));

    // ----------------------------------------
    // clock, watchdog, verdict
    // ----------------------------------------
    always #25 sys_clk = ~sys_clk;

    // about four hundred cycles are needed; over twelve times that means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d, input fap_src_type s,
        input logic refused);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_src <= s;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1 chk("refused", {15'h0, refused}, {15'h0, reg_refused});
    endtask

    task automatic rd(input logic [23:0] a, input fap_src_type s, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_src <= s;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("read data", exp, reg_rdata);
    endtask

    task automatic acc(input logic w, input logic p, input logic d, input logic pr,
        input fap_src_type s, input logic [SECT_W-1:0] sec, input logic g,
        input logic [15:0] exp);
        @(posedge sys_clk);
        acc_req <= '{valid: 1'b1, write: w, peripheral_event_transfer: p, dbg: d, primary: pr, src: s, sector: sec};
        @(posedge sys_clk);
        acc_req <= '0;
        #1 chk("grant", {15'h0, g}, {15'h0, acc_grant});
        chk("deny", {15'h0, !g}, {15'h0, acc_deny});
        chk("access data", exp, acc_rdata);
    endtask

    // protection and debug levels, given time to settle after a write
    task automatic lvl(input logic prot, input logic dbg);
        repeat (3) @(posedge sys_clk);
        #1 chk("protection", {15'h0, prot}, {15'h0, prot_active});
        chk("debug", {15'h0, dbg}, {15'h0, debug_en});
    endtask

    function automatic logic [15:0] fw(input logic [SECT_W-1:0] s);
        return 16'ha500 | 16'(s);
    endfunction

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 chk("protection in reset", 16'h1, {15'h0, prot_active});
        @(posedge sys_clk);
        rst_n <= 1'b1;
        pwr_on_n <= 1'b1;
        acc_req <= '{valid: 1'b1, write: 1'b0, peripheral_event_transfer: 1'b0, dbg: 1'b0, primary: 1'b1,
            src: SRC_PRIM_B0, sector: 6'h01};
        @(posedge sys_clk);
        acc_req <= '0;
        #1 chk("deny while loading", 16'h1, {15'h0, acc_deny});
        rd(OFF_UNLOCK, SRC_PRIM_B0, FUSE_ERASED);
        rd(OFF_RELOCK, SRC_PRIM_B0, FUSE_ERASED);
        rd(OFF_ACC_FUSE, SRC_INTERNAL_RAM, 16'h0003);
        rd(24'h0edfca, SRC_PRIM_B0, 16'h0000);
        rd(OFF_STATUS, SRC_INTERNAL_RAM, 16'h0009);
        lvl(1'b0, 1'b1);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h05, 1'b1, fw(6'h05));
        // first disable fuse needs both access and debug fuses programmed
        wr(OFF_UNLOCK, 16'hfffe, SRC_PRIM_B0, 1'b1);
        wr(OFF_ACC_FUSE, 16'hfffe, SRC_PRIM_B0, 1'b0);
        // access fuse alone: ram reads refused, an open debug fuse bypasses
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h05, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b1, 1'b1, SRC_INTERNAL_RAM, 6'h05, 1'b1, fw(6'h05));
        wr(OFF_UNLOCK, 16'hfffe, SRC_PRIM_B0, 1'b1);
        rd(OFF_UNLOCK, SRC_PRIM_B0, FUSE_ERASED);
        wr(OFF_ACC_FUSE, 16'hfffc, SRC_PRIM_B0, 1'b0);
        rd(OFF_ACC_FUSE, SRC_EXTENSION_RAM, 16'h0000);
        rd(OFF_STATUS, SRC_EXTENSION_RAM, 16'h0003);
        lvl(1'b1, 1'b0);
        // who may touch protected primary flash data
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h05, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_PRIM_B1, 6'h05, 1'b1, fw(6'h05));
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_EXT_B2, 6'h05, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b1, 1'b0, 1'b1, SRC_PRIM_B0, 6'h05, 1'b0, DUMMY_DATA);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h02, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h02, 1'b1, fw(6'h02));
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_EXT_B3, 6'h03, 1'b1, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h03, 1'b1, ~fw(6'h03));
        acc(1'b0, 1'b0, 1'b1, 1'b1, SRC_PRIM_B0, 6'h04, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_EXTMEM, 6'h05, 1'b0, DUMMY_DATA);
        acc(1'b0, 1'b0, 1'b0, 1'b0, SRC_EXTENSION_RAM, 6'h07, 1'b1, fw(6'h07));
        acc(1'b0, 1'b0, 1'b0, 1'b0, SRC_EXTMEM, 6'h08, 1'b1, fw(6'h08));
        // register writes from outside primary flash, and from bank two
        wr(OFF_WP_BASE, 16'hfffe, SRC_INTERNAL_RAM, 1'b1);
        wr(OFF_WP_BASE, 16'hfffe, SRC_EXT_B2, 1'b1);
        rd(OFF_WP_BASE, SRC_INTERNAL_RAM, FUSE_ERASED);
        // sector protect, lift and restore
        wr(OFF_WP_BASE, 16'hfffe, SRC_PRIM_B0, 1'b0);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h00, 1'b0, DUMMY_DATA);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h01, 1'b1, DUMMY_DATA);
        wr(OFF_WP_BASE, 16'hffff, SRC_PRIM_B0, 1'b0);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h00, 1'b1, DUMMY_DATA);
        rd(OFF_WP_BASE, SRC_PRIM_B0, 16'hfffe);
        wr(OFF_WP_BASE, 16'hfffe, SRC_PRIM_B0, 1'b0);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h00, 1'b0, DUMMY_DATA);
        // temporary access lift, restore by write and by reset
        wr(OFF_ACC_FUSE, 16'hffff, SRC_PRIM_B0, 1'b0);
        lvl(1'b0, 1'b0);
        rd(OFF_ACC_FUSE, SRC_PRIM_B0, 16'h0000);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h06, 1'b1, fw(6'h06));
        wr(OFF_ACC_FUSE, 16'hfffc, SRC_PRIM_B0, 1'b0);
        lvl(1'b1, 1'b0);
        wr(OFF_ACC_FUSE, 16'hffff, SRC_PRIM_B0, 1'b0);
        wr(OFF_WP_BASE, 16'hffff, SRC_PRIM_B0, 1'b0);
        lvl(1'b0, 1'b0);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        lvl(1'b1, 1'b0);
        acc(1'b1, 1'b0, 1'b0, 1'b1, SRC_PRIM_B0, 6'h00, 1'b0, DUMMY_DATA);
        // all sixteen fuse pairs, consumed strictly in order
        u = FUSE_ERASED;
        r = FUSE_ERASED;
        for (int x = 0; x < NUM_PAIRS; x++) begin
            wr(OFF_RELOCK, ~(16'h1 << x), SRC_PRIM_B0, 1'b1);
            if (x < NUM_PAIRS - 1) begin
                wr(OFF_UNLOCK, ~(16'h2 << x), SRC_PRIM_B0, 1'b1);
            end
            u = u & ~(16'h1 << x);
            wr(OFF_UNLOCK, u, SRC_PRIM_B0, 1'b0);
            lvl(1'b0, 1'b0);
            rd(OFF_STATUS, SRC_PRIM_B0, 16'h0005);
            r = r & ~(16'h1 << x);
            wr(OFF_RELOCK, r, SRC_PRIM_B0, 1'b0);
            lvl(1'b1, 1'b0);
        end
        rd(OFF_UNLOCK, SRC_PRIM_B0, 16'h0000);
        rd(OFF_RELOCK, SRC_PRIM_B0, 16'h0000);
        acc(1'b0, 1'b0, 1'b0, 1'b1, SRC_INTERNAL_RAM, 6'h05, 1'b0, DUMMY_DATA);
        results();
    end
endmodule
